// >>> logic/uhis_pkg.sv
// register map, field positions and reset values of the usb host interrupt status block
// assumes a 32-bit axi4-lite register bus with word aligned byte addresses
package uhis_pkg;
	// byte offsets of the registers
	localparam logic [7:0] CMD_STATUS_OFS = 8'h08;
	localparam logic [7:0] INT_STATUS_OFS = 8'h0c;
	localparam logic [7:0] INT_ENABLE_OFS = 8'h10;
	localparam logic [7:0] INT_DISABLE_OFS = 8'h14;
	localparam logic [7:0] EVENT_CTRL_OFS = 8'h40;
	// status bit positions
	localparam int SCHED_OVERRUN_BIT = 0;
	localparam int DONE_HEAD_WB_BIT = 1;
	localparam int FRAME_START_BIT = 2;
	localparam int RESUME_DET_BIT = 3;
	localparam int UNRECOV_ERR_BIT = 4;
	localparam int FRAME_OVF_BIT = 5;
	localparam int ROOT_HUB_CHG_BIT = 6;
	localparam int OWN_CHG_BIT = 30;
	localparam int MASTER_EN_BIT = 31;
	// command status fields
	localparam int OWN_REQ_BIT = 3;
	localparam int OVR_CNT_LO = 16;
	localparam int OVR_CNT_HI = 17;
	// event control register: bit 0 ends an ownership changeover
	localparam int OWN_DONE_BIT = 0;
	// masks of implemented bits
	localparam logic [31:0] STATUS_MASK = 32'h4000_007f;
	localparam logic [31:0] ENABLE_MASK = 32'hc000_007f;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] OVR_CNT_RESET = 2'h0;
	localparam logic [1:0] OVR_CNT_STEP = 2'h1;
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/uhis_top.sv
// interrupt status logic of a usb host core with an axi4-lite register slave
// assumes event inputs are single-cycle pulses or levels from logic on clk_i;
// the resume line is a level that may come from outside, so it is synchronised here
//
// What this block does
// - events set sticky status bits
// - interrupt needs enable and master enable
// - write one clears, zero leaves
// - software writes never set status
// - hardware never clears status bits
// - ownership request sets ownership change bit
// - enabled ownership change drives smi pin
// - ownership bit zero without smi pin
// - root hub change sets bit six
// - frame counter msb toggle sets bit five
// - system error sets bit four, halts
// - resume rising edge sets bit three
// - commanded resume does not set it
// - frame start sets bit two with sof
// - done head write-back sets bit one
// - no write-back while bit one set
// - schedule overrun sets bit zero
// - overrun increments two-bit count
// - status resets zero, reserved write zero
// - count starts zero, wraps, always counts
// - ownership request cleared after changeover

////////////////////////////////////////////////////////////////////////
// register map seen from the bus, byte addresses:
//   0x08 command status: bit 3 ownership request, writing one sets it;
//        bits 17:16 overrun count, read only
//   0x0c interrupt event status: write one clears, bits 30 and 6:0 exist
//   0x10 interrupt event enable: write one sets, bit 31 is the master enable
//   0x14 same enable register: write one clears, a read returns the enables
//   0x40 event control: writing one to bit 0 marks the changeover as done
//        and drops the ownership request; reads give zero
// any other address answers slverr, and a read of it returns zero
//
// timing seen from the bus:
//   write address and write data may come in either order; the response
//   rises one edge after both are held, and the register changes at that
//   same edge
//   read data stand from the edge that takes the address, until rready
//
// timing seen from the event sources:
//   a pulse sampled at edge n sets its status bit at edge n
//   the registered interrupt and smi follow one edge later; the write-back
//   permission drops at edge n itself
//   the resume line passes three flops and a change counts only once the
//   second and third agree, so a resume must stand for at least two
//   cycles; a one-cycle blip is taken as noise and ignored
//
// hazards a user must know:
//   a set and a software clear in the same cycle leave the bit set, so an
//   event is never lost to a clear that raced it
//   the ownership bit is set again every cycle while the request stands;
//   clear it only after the changeover has dropped the request
//   the unrecoverable error bit does not end the halt; only the error
//   correction input does
//   the ownership bit drives only the smi pin, never the host interrupt
////////////////////////////////////////////////////////////////////////
module uhis_top #(
	parameter bit HAS_SMI_PIN = 1'b1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// internal event sources
	input wire logic root_hub_change_i,
	input wire logic [15:0] frame_number_counter_i,
	input wire logic frame_number_copy_done_i,
	input wire logic system_error_i,
	input wire logic error_corrected_i,
	input wire logic resume_signal_i,
	input wire logic sof_issue_i,
	input wire logic done_head_written_i,
	input wire logic sched_overrun_i,
	// results
	output logic done_head_writeback_allow_o,
	output logic processing_halt_o,
	output logic host_irq_o,
	output logic system_mgmt_interrupt_pin_n_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	logic [31:0] status_q; // interrupt_event_status
	logic [31:0] enable_q; // interrupt_event_enable incl. master enable
	logic own_req_q; // ownership_change_request
	logic [1:0] ovr_cnt_q; // overrun count field
	logic halt_q; // processing halted by system error
	logic [15:15] fm_msb_q; // last frame counter msb
	logic res_s1_q, res_s2_q, res_s3_q; // resume synchroniser
	logic res_lvl_q; // accepted resume level
	logic [31:0] set_d; // hardware set vector
	logic [31:0] clr_d; // software clear vector
	logic aw_hold_q; // write address captured
	logic w_hold_q; // write data captured
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_go; // both halves present, response free
	logic [31:0] wmask; // byte enables spread to bits

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data accepted in either order

	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
	assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	// capture write address
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			s_axi_awready_o <= 1'b0;
		end else if (s_axi_awready_o && s_axi_awvalid_i) begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr_i;
			s_axi_awready_o <= 1'b0;
		end else if (wr_go) begin
			aw_hold_q <= 1'b0;
		end else begin
			// ready only while no address is held
			s_axi_awready_o <= !aw_hold_q;
		end
	end

	// capture write data
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			w_hold_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_wready_o <= 1'b0;
		end else if (s_axi_wready_o && s_axi_wvalid_i) begin
			w_hold_q <= 1'b1;
			w_data_q <= s_axi_wdata_i;
			w_strb_q <= s_axi_wstrb_i;
			s_axi_wready_o <= 1'b0;
		end else if (wr_go) begin
			w_hold_q <= 1'b0;
		end else begin
			s_axi_wready_o <= !w_hold_q;
		end
	end

	// write response, slverr for unmapped addresses
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= uhis_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			case (aw_addr_q)
				uhis_pkg::CMD_STATUS_OFS, uhis_pkg::INT_STATUS_OFS, uhis_pkg::INT_ENABLE_OFS,
				uhis_pkg::INT_DISABLE_OFS, uhis_pkg::EVENT_CTRL_OFS: s_axi_bresp_o <= uhis_pkg::RESP_OKAY;
				default: s_axi_bresp_o <= uhis_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: one read at a time, data one cycle after address

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= uhis_pkg::ZERO_WORD;
			s_axi_rresp_o <= uhis_pkg::RESP_OKAY;
		end else if (s_axi_arready_o && s_axi_arvalid_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= uhis_pkg::RESP_OKAY;
			case (s_axi_araddr_i)
				// command status: overrun count and ownership request
				uhis_pkg::CMD_STATUS_OFS: begin
					s_axi_rdata_o <= uhis_pkg::ZERO_WORD;
					s_axi_rdata_o[uhis_pkg::OVR_CNT_HI:uhis_pkg::OVR_CNT_LO] <= ovr_cnt_q;
					s_axi_rdata_o[uhis_pkg::OWN_REQ_BIT] <= own_req_q;
				end
				uhis_pkg::INT_STATUS_OFS: s_axi_rdata_o <= status_q;
				uhis_pkg::INT_ENABLE_OFS, uhis_pkg::INT_DISABLE_OFS: s_axi_rdata_o <= enable_q;
				uhis_pkg::EVENT_CTRL_OFS: s_axi_rdata_o <= uhis_pkg::ZERO_WORD;
				default: begin
					s_axi_rdata_o <= uhis_pkg::ZERO_WORD;
					s_axi_rresp_o <= uhis_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_o) begin
			if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end else begin
			s_axi_arready_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event detection

	// resume line: three flops, change counts when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			res_s1_q <= 1'b0;
			res_s2_q <= 1'b0;
			res_s3_q <= 1'b0;
			res_lvl_q <= 1'b0;
		end else begin
			res_s1_q <= resume_signal_i;
			res_s2_q <= res_s1_q;
			res_s3_q <= res_s2_q;
			// accept a new level only when stages two and three agree
			if (res_s2_q == res_s3_q) begin
				res_lvl_q <= res_s3_q;
			end
		end
	end

	// frame counter msb history
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fm_msb_q <= 1'b0;
		end else begin
			fm_msb_q <= frame_number_counter_i[15];
		end
	end

	// hardware set vector from the event sources
	always_comb begin
		set_d = uhis_pkg::ZERO_WORD;
		set_d[uhis_pkg::OWN_CHG_BIT] = own_req_q && HAS_SMI_PIN;
		set_d[uhis_pkg::ROOT_HUB_CHG_BIT] = root_hub_change_i;
		set_d[uhis_pkg::FRAME_OVF_BIT] = (fm_msb_q != frame_number_counter_i[15]) || frame_number_copy_done_i;
		set_d[uhis_pkg::UNRECOV_ERR_BIT] = system_error_i;
		set_d[uhis_pkg::RESUME_DET_BIT] = res_s2_q && res_s3_q && !res_lvl_q;
		set_d[uhis_pkg::FRAME_START_BIT] = sof_issue_i;
		set_d[uhis_pkg::DONE_HEAD_WB_BIT] = done_head_written_i;
		set_d[uhis_pkg::SCHED_OVERRUN_BIT] = sched_overrun_i;
	end

	// software clear vector on a write to the status register
	always_comb begin
		clr_d = uhis_pkg::ZERO_WORD;
		if (wr_go && aw_addr_q == uhis_pkg::INT_STATUS_OFS) begin
			clr_d = w_data_q & wmask & uhis_pkg::STATUS_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	// status bits: set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			status_q <= uhis_pkg::ZERO_WORD;
		end else begin
			status_q <= ((status_q & ~clr_d) | set_d) & uhis_pkg::STATUS_MASK;
		end
	end

	// enable register: set through its own offset, cleared through the disable offset
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			enable_q <= uhis_pkg::ZERO_WORD;
		end else if (wr_go && aw_addr_q == uhis_pkg::INT_ENABLE_OFS) begin
			enable_q <= enable_q | (w_data_q & wmask & uhis_pkg::ENABLE_MASK);
		end else if (wr_go && aw_addr_q == uhis_pkg::INT_DISABLE_OFS) begin
			enable_q <= enable_q & ~(w_data_q & wmask & uhis_pkg::ENABLE_MASK);
		end
	end

	// ownership change request bit
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			own_req_q <= 1'b0;
		end else if (wr_go && aw_addr_q == uhis_pkg::CMD_STATUS_OFS && wmask[uhis_pkg::OWN_REQ_BIT]
				&& w_data_q[uhis_pkg::OWN_REQ_BIT]) begin
			// software request sets it
			own_req_q <= 1'b1;
		end else if (wr_go && aw_addr_q == uhis_pkg::EVENT_CTRL_OFS && wmask[uhis_pkg::OWN_DONE_BIT]
				&& w_data_q[uhis_pkg::OWN_DONE_BIT]) begin
			own_req_q <= 1'b0;
		end
	end

	// overrun count
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ovr_cnt_q <= uhis_pkg::OVR_CNT_RESET;
		end else if (sched_overrun_i) begin
			ovr_cnt_q <= ovr_cnt_q + uhis_pkg::OVR_CNT_STEP;
		end
	end

	// halt after system error until corrected
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			halt_q <= 1'b0;
		end else if (system_error_i) begin
			halt_q <= 1'b1;
		end else if (error_corrected_i) begin
			halt_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// interrupt, smi and write-back permission, all registered
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			host_irq_o <= 1'b0;
			system_mgmt_interrupt_pin_n_o <= 1'b1;
			done_head_writeback_allow_o <= 1'b0;
			processing_halt_o <= 1'b0;
		end else begin
			host_irq_o <= enable_q[uhis_pkg::MASTER_EN_BIT]
				&& |(status_q & enable_q & uhis_pkg::STATUS_MASK & ~(32'h1 << uhis_pkg::OWN_CHG_BIT));
			system_mgmt_interrupt_pin_n_o <= !(HAS_SMI_PIN && status_q[uhis_pkg::OWN_CHG_BIT]
				&& enable_q[uhis_pkg::OWN_CHG_BIT]);
			done_head_writeback_allow_o <= !status_q[uhis_pkg::DONE_HEAD_WB_BIT] && !set_d[uhis_pkg::DONE_HEAD_WB_BIT];
			processing_halt_o <= halt_q || system_error_i;
		end
	end

endmodule

// >>> sim/uhis_check_properties.sv
// port assertions of the usb host interrupt status block
// assumes one clock domain and a synchronous active low reset
module uhis_check (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic done_head_written_i,
	input wire logic system_error_i,
	input wire logic error_corrected_i,
	input wire logic done_head_writeback_allow_o,
	input wire logic processing_halt_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////
	// both write halves taken at one edge
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// a held response, not yet taken
	sequence s_b_wait;
		s_axi_bvalid_o && !s_axi_bready_i;
	endsequence
	AST_WR_RESP: assert property (s_wr_take |-> ##2 s_axi_bvalid_o) else $error("write response late");
	AST_RD_RESP: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read late");
	AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp moved");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o)) else $error("rdata moved");
	AST_ALLOW_DROP: assert property (done_head_written_i |-> ##[2:3] !done_head_writeback_allow_o) else $error("allow kept");
	AST_ALLOW_HOLD: assert property (!done_head_writeback_allow_o && !s_axi_bvalid_o && !$past(s_axi_bvalid_o)
		&& $past(reset_n_i, 2) |=> !done_head_writeback_allow_o) else $error("allow rose alone");
	AST_HALT_SET: assert property (system_error_i |-> ##[1:2] processing_halt_o) else $error("no halt");
	AST_HALT_HOLD: assert property (processing_halt_o && !error_corrected_i && !$past(error_corrected_i)
		|=> processing_halt_o) else $error("halt ended alone");
endmodule

bind uhis_top uhis_check u_chk (.clk_i, .reset_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .done_head_written_i, .system_error_i,
	.error_corrected_i, .done_head_writeback_allow_o, .processing_halt_o);

// >>> sim/uhis_top_tb.sv
// self-checking bench of the usb host interrupt status block
// assumes the package, the design and the bound checker are compiled first
module uhis_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_n_i = 1'b0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, error_corrected_i = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [6:0] ev = 7'h00; // one event line per status bit 6 to 0
	logic [15:0] fcnt = 16'h0000;
	logic allow, halt, irq, smi_n;
	logic [31:0] m_st = 32'h0000_0000, m_en = 32'h0000_0000, rnd = 32'hf5c194ff; // model state
	int m_cnt = 0, bad_count = 0, checked = 0;
	bit m_req = 1'b0, m_halt = 1'b0;
	always #5 clk_i = ~clk_i;
	uhis_top u_dut (.clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .root_hub_change_i(ev[6]), .frame_number_counter_i(fcnt),
		.frame_number_copy_done_i(ev[5]), .system_error_i(ev[4]), .error_corrected_i,
		.resume_signal_i(ev[3]), .sof_issue_i(ev[2]), .done_head_written_i(ev[1]), .sched_overrun_i(ev[0]),
		.done_head_writeback_allow_o(allow), .processing_halt_o(halt), .host_irq_o(irq),
		.system_mgmt_interrupt_pin_n_o(smi_n));
	////////////////////////////////////////////////////////////////
	// next pseudo random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// compare one result
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// axi4-lite write, halves released as taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
		@(posedge clk_i);
	endtask
	// axi4-lite read with expected word
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b0;
		chk("rdata", ed, s_axi_rdata_o);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
		@(posedge clk_i);
	endtask
	// one cycle event on status source i, three cycles for the resume line
	task automatic pulse(input int i);
		ev <= 7'h01 << i;
		// the resume line is filtered; it needs two cycles and is held three
		repeat ((i == 3) ? 3 : 1) @(posedge clk_i);
		ev <= 7'h00;
		repeat (6) @(posedge clk_i);
		m_st[i] = 1'b1;
		if (i == 0) m_cnt++;
		if (i == 4) m_halt = 1'b1;
	endtask
	// status, command word and all result pins against the model
	task automatic look(input string t);
		rd(uhis_pkg::INT_STATUS_OFS, m_st, uhis_pkg::RESP_OKAY);
		rd(uhis_pkg::CMD_STATUS_OFS, {14'h0, m_cnt[1:0], 12'h0, m_req, 3'h0}, uhis_pkg::RESP_OKAY);
		chk("irq", {31'h0, |(m_st[6:0] & m_en[6:0]) & m_en[31]}, {31'h0, irq});
		chk("smi_n", {31'h0, ~(m_st[30] & m_en[30])}, {31'h0, smi_n});
		chk("allow", {31'h0, ~m_st[1]}, {31'h0, allow});
		chk("halt", {31'h0, m_halt}, {31'h0, halt});
		$display("test %s done", t);
	endtask
	task automatic test_done();
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog far beyond the expected run of under three hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd(8'h3c, uhis_pkg::ZERO_WORD, uhis_pkg::RESP_SLVERR);
		wr(8'h3c, 32'hffff_ffff, uhis_pkg::RESP_SLVERR);
		wr(uhis_pkg::INT_STATUS_OFS, uhis_pkg::STATUS_MASK, uhis_pkg::RESP_OKAY);
		look("reset");
		wr(uhis_pkg::INT_ENABLE_OFS, uhis_pkg::ENABLE_MASK, uhis_pkg::RESP_OKAY);
		m_en = uhis_pkg::ENABLE_MASK;
		for (int i = 0; i < 7; i++) begin
			pulse(i);
			look("event");
		end
		rnd = lfsr(rnd);
		wr(uhis_pkg::INT_STATUS_OFS, rnd & uhis_pkg::STATUS_MASK, uhis_pkg::RESP_OKAY);
		m_st = m_st & ~(rnd & uhis_pkg::STATUS_MASK);
		look("partial clear");
		wr(uhis_pkg::INT_STATUS_OFS, uhis_pkg::STATUS_MASK, uhis_pkg::RESP_OKAY);
		m_st = 32'h0000_0000;
		rnd = lfsr(rnd);
		fcnt <= {~fcnt[15], rnd[14:0]};
		repeat (6) @(posedge clk_i);
		m_st[5] = 1'b1;
		look("frame wrap");
		wr(uhis_pkg::INT_DISABLE_OFS, 32'h8000_0000, uhis_pkg::RESP_OKAY);
		m_en[31] = 1'b0;
		pulse(2);
		look("master off");
		wr(uhis_pkg::INT_ENABLE_OFS, 32'h8000_0000, uhis_pkg::RESP_OKAY);
		m_en[31] = 1'b1;
		rd(uhis_pkg::INT_DISABLE_OFS, m_en, uhis_pkg::RESP_OKAY);
		repeat (4) pulse(0);
		look("overrun wrap");
		wr(uhis_pkg::CMD_STATUS_OFS, 32'h0000_0008, uhis_pkg::RESP_OKAY);
		m_req = 1'b1;
		m_st[30] = 1'b1;
		look("ownership");
		wr(uhis_pkg::EVENT_CTRL_OFS, 32'h0000_0001, uhis_pkg::RESP_OKAY);
		m_req = 1'b0;
		wr(uhis_pkg::INT_STATUS_OFS, 32'h4000_0000, uhis_pkg::RESP_OKAY);
		m_st[30] = 1'b0;
		error_corrected_i <= 1'b1;
		@(posedge clk_i);
		error_corrected_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		m_halt = 1'b0;
		look("handback");
		wr(uhis_pkg::INT_STATUS_OFS, uhis_pkg::STATUS_MASK, uhis_pkg::RESP_OKAY);
		m_st = 32'h0000_0000;
		look("all clear");
		test_done();
	end
endmodule
